// ===== hdl/tsw_pkg.sv
package tsw_pkg;
  // ----------------------------------------------------------------
  // widths and geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W    = 16;
  localparam int DATA_W    = 16;
  localparam int NSTR_DEF  = 64;
  localparam int FIFO_DEP  = 16;
  localparam int HA_W      = 4;
  localparam int LANE_W    = 8;
  // ----------------------------------------------------------------
  // device register map (word addresses on the port)
  // ----------------------------------------------------------------
  localparam logic [15:0] DEV_CR     = 16'h0000;
  localparam logic [15:0] DEV_RRATE  = 16'h0001;
  localparam logic [15:0] DEV_TRATE  = 16'h0002;
  localparam logic [15:0] DEV_FLT0   = 16'h0010;
  localparam logic [15:0] DEV_TXFIFO = 16'h0020;
  localparam logic [15:0] DEV_RXWORD = 16'h0021;
  localparam logic [15:0] DEV_STAT   = 16'h0022;
  localparam int CR_OSB = 0;
  localparam int CR_OEI = 1;
  localparam logic [15:0] CR_RST  = 16'h0000;
  // ----------------------------------------------------------------
  // host controller register map
  // ----------------------------------------------------------------
  localparam logic [3:0] H_ADDR  = 4'h0;
  localparam logic [3:0] H_WDATA = 4'h1;
  localparam logic [3:0] H_CTRL  = 4'h2;
  localparam logic [3:0] H_STAT  = 4'h3;
  localparam logic [3:0] H_RDATA = 4'h4;
  localparam int CTL_GO  = 0;
  localparam int CTL_RD  = 1;
  localparam int CTL_BEL = 2;
  localparam int CTL_BEH = 3;
  // ----------------------------------------------------------------
  // rates and timing
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    TSW_R2M  = 3'b000,
    TSW_R4M  = 3'b001,
    TSW_R8M  = 3'b010,
    TSW_R16M = 3'b011,
    TSW_R32M = 3'b100
  } tsw_rate_t;
  localparam logic [3:0] DIV_FULL = 4'hf;
  localparam logic [2:0] IDLE_RUN = 3'h4;
  localparam int CLK_NS       = 40;
  localparam int STROBE_NS    = 120;
  localparam int STROBE_CYC   = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RESET_MIN_NS = 20;
  localparam int ACK_TMO_CYC  = 64;
  typedef enum logic [1:0] {
    TSW_A_IDLE = 2'b00,
    TSW_A_WAIT = 2'b01,
    TSW_A_LOW  = 2'b10,
    TSW_A_HIGH = 2'b11
  } tsw_ack_t;
  typedef enum logic [1:0] {
    TSW_H_IDLE   = 2'b00,
    TSW_H_SETUP  = 2'b01,
    TSW_H_STROBE = 2'b10,
    TSW_H_HOLD   = 2'b11
  } tsw_hst_t;
endpackage

// ===== hdl/tsw_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tsw_if;
  logic        cs_n;
  logic        ds_n;
  logic        rw;
  logic        sync_mode;
  logic [15:0] addr;
  logic        bel_n;
  logic [15:0] d_host;
  logic        d_host_oe_n;
  logic [15:0] d_dev;
  logic [1:0]  d_dev_oe_n;
  logic        beh_host;
  logic        beh_host_oe_n;
  logic        dta_dev;
  logic        dta_dev_oe_n;
  logic [15:0] d_bus;
  logic        dtabeh;
  // wire resolution; undriven lines float up as through pull-ups
  assign d_bus[7:0]  = !d_dev_oe_n[0] ? d_dev[7:0] :
                       !d_host_oe_n ? d_host[7:0] : 8'hff;
  assign d_bus[15:8] = !d_dev_oe_n[1] ? d_dev[15:8] :
                       !d_host_oe_n ? d_host[15:8] : 8'hff;
  assign dtabeh = !dta_dev_oe_n ? dta_dev :
                  !beh_host_oe_n ? beh_host : 1'b1;
  modport dev  (input cs_n, ds_n, rw, sync_mode, addr, bel_n, d_bus,
                dtabeh, output d_dev, d_dev_oe_n, dta_dev, dta_dev_oe_n);
  modport host (output cs_n, ds_n, rw, sync_mode, addr, bel_n, d_host,
                d_host_oe_n, beh_host, beh_host_oe_n,
                input d_bus, dtabeh);
endinterface
`default_nettype wire

// ===== hdl/tsw_dev.sv
// Summary of operation
// (RL1) sync mode: low enable gates low byte
// (RL2) sync mode: shared pin input gates high byte
// (RL3) async mode: acknowledge driven low on completion
// (RL4) cycle end: drive acknowledge high, then release
// (RL5) port responds only while chip select low
// (RL6) access needs data strobe and chip select
// (RL7) read/write sets direction; device drives reads
// (RL8) sixteen address bits reach every register
// (RL9) drive enable and standby low: outputs float; status pins stay driven when CR_OEI is set
// (RL10) drive enable high: per-channel float bits apply
// (RL11) reset clears state, floats serial and data
// (RL12) reset held low at least 20 ns
// (RL13) strap selects sync or async bus timing
// (RL14) async mode: host ties low enable low
// (RL15) serial bit clock shifts stream data
// (RL16) frame pulse polarity identified automatically
// (RL17) receive rate: five rates via rate register
// (RL18) indication pins show drive status when selected
// (RL19) unenabled byte lanes float on sync reads
`timescale 1ns/1ps
`default_nettype none
module tsw_fifo #(
  parameter int W   = 16,
  parameter int DEP = 16
) (
  input  wire logic         i_clk_sys,
  input  wire logic         i_nrst,
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_out_valid,
  input  wire logic         i_out_ready,
  output logic [W-1:0]      o_out_data
);
  localparam int AW = $clog2(DEP);
  logic [W-1:0] mem_q [DEP];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0]   cnt_q;
  logic push;
  logic pop;
  assign o_in_ready  = (cnt_q != (AW+1)'(DEP));
  assign o_out_valid = (cnt_q != '0);
  assign o_out_data  = mem_q[rp_q];
  assign push = i_in_valid & o_in_ready;
  assign pop  = o_out_valid & i_out_ready;
  always_ff @(posedge i_clk_sys) begin
    if (push) begin
      mem_q[wp_q] <= i_in_data;
    end
  end
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wp_q <= AW'((DEP == (1 << AW)) ? wp_q + 1'b1 :
                            (wp_q == AW'(DEP-1)) ? 0 : wp_q + 1'b1);
      if (pop) rp_q <= AW'((DEP == (1 << AW)) ? rp_q + 1'b1 :
                           (rp_q == AW'(DEP-1)) ? 0 : rp_q + 1'b1);
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module tsw_dev #(
  parameter int NSTR = tsw_pkg::NSTR_DEF
) (
  input  wire logic            i_clk_sys,
  input  wire logic            i_nrst,
  tsw_if.dev                   p,
  input  wire logic            i_serial_bit_clock,
  input  wire logic            i_frame_pulse_in,
  input  wire logic            i_output_drive_enable_in,
  input  wire logic [NSTR-1:0] i_rx,
  output logic      [NSTR-1:0] o_tx,
  output logic      [NSTR-1:0] o_tx_oe_n,
  output logic                 o_frame_high_active
);
  import tsw_pkg::*;
  localparam int NFW = (NSTR + DATA_W - 1) / DATA_W;
  logic live_q, sync_q, acc_q, access, acc_start, take, wr, ovf_q;
  logic [15:0] cr_q, rd_q, rd_d, rxword_q, wmask;
  tsw_rate_t rrate_q, trate_q;
  logic [15:0] flt_q [NFW];
  tsw_ack_t ack_q;
  logic f_ready, f_valid, f_pop;
  logic [15:0] f_data;
  // ----------------------------------------------------------------
  // port access decode
  // ----------------------------------------------------------------
  // (RL5) (RL6) chip select and strobe
  assign access    = live_q & !p.cs_n & !p.ds_n;
  assign acc_start = access & !acc_q;
  // async writes to the full fifo hold off the acknowledge instead
  // (RL3) async take point
  assign take = sync_q ? acc_start :
                (ack_q == TSW_A_WAIT) & access &
                (p.rw | (p.addr != DEV_TXFIFO) | f_ready);
  // (RL7) writes only when direction says write
  assign wr = take & !p.rw;
  // (RL1) (RL2) byte enables only matter in sync mode
  assign wmask = sync_q ? {{LANE_W{!p.dtabeh}}, {LANE_W{!p.bel_n}}}
                        : 16'hffff;
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      live_q <= 1'b0;
      acc_q  <= 1'b0;
    end else begin
      live_q <= 1'b1;
      acc_q  <= access;
    end
  end
  // (RL13) strap caught the cycle after reset release
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) sync_q <= 1'b0;
    else if (!live_q) sync_q <= p.sync_mode;
  end
  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  // (RL8) (RL11) full address decode, cleared on reset
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      cr_q    <= CR_RST;
      rrate_q <= TSW_R2M;
      trate_q <= TSW_R2M;
      for (int i = 0; i < NFW; i++) flt_q[i] <= '0;
    end else if (wr) begin
      if (p.addr == DEV_CR)
        cr_q <= (cr_q & ~wmask) | (p.d_bus & wmask);
      // (RL17) rate codes above the fastest are ignored
      if (p.addr == DEV_RRATE && wmask[0] && p.d_bus[2:0] <= TSW_R32M)
        rrate_q <= tsw_rate_t'(p.d_bus[2:0]);
      if (p.addr == DEV_TRATE && wmask[0] && p.d_bus[2:0] <= TSW_R32M)
        trate_q <= tsw_rate_t'(p.d_bus[2:0]);
      for (int i = 0; i < NFW; i++)
        if (p.addr == DEV_FLT0 + 16'(i))
          flt_q[i] <= (flt_q[i] & ~wmask) | (p.d_bus & wmask);
    end
  end
  always_comb begin
    rd_d = 16'h0000;
    unique case (p.addr)
      DEV_CR:     rd_d = cr_q;
      DEV_RRATE:  rd_d = {13'h0000, rrate_q};
      DEV_TRATE:  rd_d = {13'h0000, trate_q};
      DEV_RXWORD: rd_d = rxword_q;
      DEV_STAT:   rd_d = {12'h000, o_frame_high_active, ovf_q,
                          !f_ready, !f_valid};
      default: begin
        for (int i = 0; i < NFW; i++)
          if (p.addr == DEV_FLT0 + 16'(i)) rd_d = flt_q[i];
      end
    endcase
  end
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) rd_q <= '0;
    else if (take & p.rw) rd_q <= rd_d;
  end
  // overflow: a dropped sync write wins over a clearing write
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) ovf_q <= 1'b0;
    else if (wr & (p.addr == DEV_TXFIFO) & !f_ready) ovf_q <= 1'b1;
    else if (wr & (p.addr == DEV_STAT)) ovf_q <= 1'b0;
  end
  // ----------------------------------------------------------------
  // data and acknowledge pins
  // ----------------------------------------------------------------
  assign p.d_dev = rd_q;
  // (RL1) (RL2) (RL19) lanes driven on reads; in sync mode only when enabled
  assign p.d_dev_oe_n[0] = !(access & p.rw & (!sync_q | !p.bel_n));
  assign p.d_dev_oe_n[1] = !(access & p.rw & (!sync_q | !p.dtabeh));
  // (RL3) (RL4) low while acknowledged, high one cycle, then off
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) ack_q <= TSW_A_IDLE;
    else begin
      unique case (ack_q)
        TSW_A_IDLE: if (access & !sync_q) ack_q <= TSW_A_WAIT;
        TSW_A_WAIT: if (!access) ack_q <= TSW_A_IDLE;
                    else if (take) ack_q <= TSW_A_LOW;
        TSW_A_LOW:  if (!access) ack_q <= TSW_A_HIGH;
        TSW_A_HIGH: ack_q <= TSW_A_IDLE;
      endcase
    end
  end
  assign p.dta_dev      = (ack_q == TSW_A_HIGH);
  assign p.dta_dev_oe_n = !((ack_q == TSW_A_LOW) | (ack_q == TSW_A_HIGH));
  // ----------------------------------------------------------------
  // serial timing: bit clock, frame format, rate dividers
  // ----------------------------------------------------------------
  logic bclk_q, bclk_p, bedge, fp_p, idle_q, fstart, tx_tick, rx_tick;
  logic [2:0] run_q;
  logic [3:0] div_q, bits_q, rxn_q;
  logic [15:0] sh_q, rxsh_q;
  // (RL15) bit clock sampled and edge detected
  assign bedge = bclk_q & !bclk_p;
  // (RL16) a pulse is any departure from the learned idle level
  assign fstart = bedge & (i_frame_pulse_in != idle_q) & (fp_p == idle_q);
  assign o_frame_high_active = !idle_q;
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      bclk_q <= 1'b0;
      bclk_p <= 1'b0;
      fp_p   <= 1'b1;
      idle_q <= 1'b1;
      run_q  <= '0;
    end else begin
      bclk_q <= i_serial_bit_clock;
      bclk_p <= bclk_q;
      if (bedge) begin
        fp_p  <= i_frame_pulse_in;
        run_q <= (i_frame_pulse_in != fp_p) ? 3'h0 :
                 (run_q == IDLE_RUN) ? run_q : run_q + 3'h1;
        if (run_q == IDLE_RUN) idle_q <= fp_p;
      end
    end
  end
  // (RL17) divide the bit clock by 16, 8, 4, 2 or 1
  assign tx_tick = bedge & ((div_q & (DIV_FULL >> trate_q))
                            == (DIV_FULL >> trate_q));
  assign rx_tick = bedge & ((div_q & (DIV_FULL >> rrate_q))
                            == (DIV_FULL >> rrate_q));
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) div_q <= '0;
    else if (fstart) div_q <= '0;
    else if (bedge) div_q <= div_q + 4'h1;
  end
  // ----------------------------------------------------------------
  // transmit path through the fifo, receive word capture
  // ----------------------------------------------------------------
  tsw_fifo #(.W(DATA_W), .DEP(FIFO_DEP)) u_fifo (
    .i_clk_sys  (i_clk_sys),
    .i_nrst     (i_nrst),
    .i_in_valid (wr & (p.addr == DEV_TXFIFO)),
    .o_in_ready (f_ready),
    .i_in_data  (p.d_bus),
    .o_out_valid(f_valid),
    .i_out_ready(f_pop),
    .o_out_data (f_data)
  );
  assign f_pop = tx_tick & (bits_q == 4'h0);
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      sh_q   <= '0;
      bits_q <= '0;
    end else if (tx_tick) begin
      if (bits_q != 4'h0) begin
        sh_q   <= {sh_q[14:0], 1'b0};
        bits_q <= bits_q - 4'h1;
      end else if (f_valid) begin
        sh_q   <= f_data;
        bits_q <= DIV_FULL;
      end else sh_q <= '0;
    end
  end
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      rxsh_q   <= '0;
      rxn_q    <= '0;
      rxword_q <= '0;
    end else if (fstart) rxn_q <= '0;
    else if (rx_tick) begin
      rxsh_q <= {rxsh_q[14:0], i_rx[0]};
      rxn_q  <= rxn_q + 4'h1;
      if (rxn_q == DIV_FULL) rxword_q <= {rxsh_q[14:0], i_rx[0]};
    end
  end
  // ----------------------------------------------------------------
  // transmit pin drive per stream
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NSTR; g++) begin : g_tx
    logic en;
    logic output_enable_indication;
    // (RL9) (RL10) (RL11) standby, drive enable, channel float
    assign en = live_q & (i_output_drive_enable_in | cr_q[CR_OSB])
                & !flt_q[g / DATA_W][g % DATA_W];
    // (RL18) upper half of each group of 16 can show status
    assign output_enable_indication = ((g % DATA_W) >= LANE_W) & cr_q[CR_OEI];
    assign o_tx[g]      = output_enable_indication ? en : sh_q[15];
    assign o_tx_oe_n[g] = output_enable_indication ? !live_q : !en;
  end
endmodule
`default_nettype wire

// ===== hdl/tsw_host.sv
`timescale 1ns/1ps
`default_nettype none
module tsw_host (
  input  wire logic        i_clk_sys,
  input  wire logic        i_nrst,
  tsw_if.host              p,
  input  wire logic        i_sync_mode,
  input  wire logic [3:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [15:0] o_rdata,
  output logic             o_busy
);
  import tsw_pkg::*;
  tsw_hst_t st_q;
  logic [15:0] tadr_q, wdat_q, rdat_q;
  logic [3:0]  ctl_q;
  logic [6:0]  cnt_q;
  logic done_q, tmo_q, go, fin, act, ack;
  // ----------------------------------------------------------------
  // command registers
  // ----------------------------------------------------------------
  assign go  = i_wr & (i_addr == H_CTRL) & i_wdata[CTL_GO]
               & (st_q == TSW_H_IDLE);
  assign ack = !p.dtabeh;
  // (RL3) async ends on acknowledge, sync after a fixed strobe
  assign fin = (st_q == TSW_H_STROBE) &
               (i_sync_mode ? (cnt_q == 7'(STROBE_CYC - 1)) :
                (ack | (cnt_q == 7'(ACK_TMO_CYC - 1))));
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      tadr_q <= '0;
      wdat_q <= '0;
      ctl_q  <= '0;
    end else if (i_wr & (st_q == TSW_H_IDLE)) begin
      if (i_addr == H_ADDR) tadr_q <= i_wdata;
      if (i_addr == H_WDATA) wdat_q <= i_wdata;
      if (i_addr == H_CTRL) ctl_q <= i_wdata[3:0];
    end
  end
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      done_q <= 1'b0;
      tmo_q  <= 1'b0;
      rdat_q <= '0;
    end else if (go) begin
      done_q <= 1'b0;
      tmo_q  <= 1'b0;
    end else if (fin) begin
      done_q <= 1'b1;
      tmo_q  <= !i_sync_mode & !ack;
      if (ctl_q[CTL_RD]) rdat_q <= p.d_bus;
    end
  end
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) o_rdata <= '0;
    else if (i_rd) begin
      unique case (i_addr)
        H_ADDR:  o_rdata <= tadr_q;
        H_WDATA: o_rdata <= wdat_q;
        H_CTRL:  o_rdata <= {12'h000, ctl_q};
        H_STAT:  o_rdata <= {13'h0000, tmo_q, done_q, o_busy};
        H_RDATA: o_rdata <= rdat_q;
        default: o_rdata <= 16'h0000;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // bus cycle sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      st_q  <= TSW_H_IDLE;
      cnt_q <= '0;
    end else begin
      cnt_q <= (st_q == TSW_H_STROBE) ? cnt_q + 7'h01 : 7'h00;
      unique case (st_q)
        TSW_H_IDLE:   if (go) st_q <= TSW_H_SETUP;
        TSW_H_SETUP:  st_q <= TSW_H_STROBE;
        TSW_H_STROBE: if (fin) st_q <= TSW_H_HOLD;
        TSW_H_HOLD:   st_q <= TSW_H_IDLE;
      endcase
    end
  end
  assign o_busy = (st_q != TSW_H_IDLE);
  assign act    = (st_q != TSW_H_IDLE);
  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------
  // (RL5) chip select frames the whole cycle
  assign p.cs_n = !act;
  // (RL6) strobe only in the strobe phase
  assign p.ds_n = (st_q != TSW_H_STROBE);
  // (RL7) direction, and write data only on writes
  assign p.rw          = ctl_q[CTL_RD];
  assign p.addr        = tadr_q;
  assign p.d_host      = wdat_q;
  assign p.d_host_oe_n = !(act & !ctl_q[CTL_RD]);
  // (RL13) strap passed to the device
  assign p.sync_mode = i_sync_mode;
  // (RL14) low enable held low in async mode
  assign p.bel_n = i_sync_mode ? !(act & ctl_q[CTL_BEL]) : 1'b0;
  // (RL2) high enable driven only in sync mode
  assign p.beh_host      = !(act & ctl_q[CTL_BEH]);
  assign p.beh_host_oe_n = !i_sync_mode;
endmodule
`default_nettype wire

// ===== tb/tsw_checker.sv
`timescale 1ns/1ps
`default_nettype none
module tsw_checker (
  input wire logic       i_clk_sys,
  input wire logic       i_nrst,
  input wire logic       cs_n,
  input wire logic       ds_n,
  input wire logic       rw,
  input wire logic       sync_mode,
  input wire logic       bel_n,
  input wire logic       dtabeh,
  input wire logic [1:0] d_dev_oe_n,
  input wire logic       dta_dev,
  input wire logic       dta_dev_oe_n
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_nrst);

  // ----------------------------------------------------------------
  // acknowledge sequences
  // ----------------------------------------------------------------
  sequence s_ack_low;
    !dta_dev_oe_n && !dta_dev;
  endsequence
  sequence s_ack_high;
    !dta_dev_oe_n && dta_dev;
  endsequence
  sequence s_ack_drop;
    s_ack_low ##1 (dta_dev_oe_n || dta_dev);
  endsequence
  sequence s_async_rd;
    rw && !sync_mode && !cs_n && $fell(ds_n);
  endsequence

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  // lanes may lag the enable by one cycle, so the past value also counts
  property p_low_lane;
    sync_mode && !d_dev_oe_n[0] |-> !bel_n || $past(!bel_n);
  endproperty
  property p_high_lane;
    sync_mode && !d_dev_oe_n[1] |-> !dtabeh || $past(!dtabeh);
  endproperty
  property p_sync_role;
    sync_mode |-> dta_dev_oe_n;
  endproperty
  property p_ack_cause;
    s_ack_low |-> $past(!cs_n && !ds_n);
  endproperty
  property p_ack_time;
    s_async_rd |-> ##[2:8] s_ack_low;
  endproperty
  property p_ack_end;
    s_ack_drop |-> s_ack_high ##1 dta_dev_oe_n;
  endproperty
  property p_read_only;
    d_dev_oe_n != 2'b11 |-> rw || $past(rw);
  endproperty
  property p_select;
    cs_n && $past(cs_n) |-> d_dev_oe_n == 2'b11 && (dta_dev_oe_n || dta_dev);
  endproperty
  // reset itself is the antecedent here, so no disable
  property p_reset_float;
    disable iff (1'b0) !i_nrst |-> d_dev_oe_n == 2'b11 && dta_dev_oe_n;
  endproperty

  a_low_lane: assert property (p_low_lane)
    else $error("low lane driven without its enable");
  a_high_lane: assert property (p_high_lane)
    else $error("high lane driven without its enable");
  a_sync_role: assert property (p_sync_role)
    else $error("shared pin driven in sync mode");
  a_ack_cause: assert property (p_ack_cause)
    else $error("acknowledge low outside an access");
  a_ack_time: assert property (p_ack_time)
    else $error("async read never acknowledged");
  a_ack_end: assert property (p_ack_end)
    else $error("acknowledge not driven high before release");
  a_read_only: assert property (p_read_only)
    else $error("data driven during a write");
  a_select: assert property (p_select)
    else $error("port active while chip select high");
  a_reset_float: assert property (p_reset_float)
    else $error("port pins driven during reset");
endmodule
`default_nettype wire

// ===== tb/tdm_switch_host_port_pins_bench.sv
`timescale 1ns/1ps
`default_nettype none
module tdm_switch_host_port_pins_bench;
  import tsw_pkg::*;
  typedef struct packed {
    logic [15:0] a;
    logic [15:0] w;
    logic        bl;
    logic        bh;
    logic [15:0] e;
  } tsw_row_t;
  logic        clk_sys;
  logic        nrst;
  logic        sync_mode;
  logic [3:0]  haddr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic [15:0] rdata;
  logic        busy;
  logic        sbclk;
  logic        frame;
  logic        output_drive_enable_in;
  logic [63:0] rx;
  logic [63:0] tx;
  logic [63:0] tx_oe_n;
  logic        frame_hi;
  logic [15:0] d;
  int          errors;
  int          tests_run;
  // unenabled lanes read back as the pull-up level
  tsw_row_t    rows [5] = '{
    '{DEV_FLT0, 16'ha5c3, 1'b1, 1'b1, 16'ha5c3},
    '{DEV_FLT0, 16'ha5c3, 1'b1, 1'b0, 16'hffc3},
    '{DEV_FLT0, 16'ha5c3, 1'b0, 1'b1, 16'ha5ff},
    '{16'h0013, 16'h5a3c, 1'b1, 1'b1, 16'h5a3c},
    '{DEV_TRATE, 16'h0002, 1'b1, 1'b1, 16'h0002}};

  tsw_if u_tsw_if();
  tsw_host u_tsw_host (.i_clk_sys(clk_sys), .i_nrst(nrst),
    .p(u_tsw_if.host), .i_sync_mode(sync_mode), .i_addr(haddr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_busy(busy));
  tsw_dev u_tsw_dev (.i_clk_sys(clk_sys), .i_nrst(nrst), .p(u_tsw_if.dev),
    .i_serial_bit_clock(sbclk), .i_frame_pulse_in(frame),
    .i_output_drive_enable_in(output_drive_enable_in), .i_rx(rx), .o_tx(tx),
    .o_tx_oe_n(tx_oe_n), .o_frame_high_active(frame_hi));
  tsw_checker u_tsw_checker (.i_clk_sys(clk_sys), .i_nrst(nrst),
    .cs_n(u_tsw_if.cs_n), .ds_n(u_tsw_if.ds_n), .rw(u_tsw_if.rw),
    .sync_mode(u_tsw_if.sync_mode), .bel_n(u_tsw_if.bel_n),
    .dtabeh(u_tsw_if.dtabeh), .d_dev_oe_n(u_tsw_if.d_dev_oe_n),
    .dta_dev(u_tsw_if.dta_dev), .dta_dev_oe_n(u_tsw_if.dta_dev_oe_n));

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic hwr(input logic [3:0] a, input logic [15:0] v);
    haddr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  // read data is taken one edge after the strobe is sampled, after it has updated
  task automatic hrd(input logic [3:0] a, output logic [15:0] v);
    haddr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    @(posedge clk_sys);
    v = rdata;
  endtask
  task automatic dev_op(input logic [15:0] a, input logic [15:0] w,
                        input logic rdn, input logic bl, input logic bh);
    logic [15:0] c;
    int n;
    c = 16'h0000;
    c[CTL_GO] = 1'b1;
    c[CTL_RD] = rdn;
    c[CTL_BEL] = bl;
    c[CTL_BEH] = bh;
    hwr(H_ADDR, a);
    hwr(H_WDATA, w);
    hwr(H_CTRL, c);
    for (n = 0; n < 200; n++) begin
      @(posedge clk_sys);
      if (n > 1 && busy === 1'b0) break;
    end
    if (n == 200) begin
      errors++;
      stop_test();
    end
    if (rdn) hrd(H_RDATA, d);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    sync_mode = 1'b1;
    haddr = 4'h0;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    sbclk = 1'b0;
    frame = 1'b0;
    output_drive_enable_in = 1'b0;
    rx = '0;
    errors = 0;
    tests_run = 0;
    // reset held three cycles, well above its minimum
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    foreach (rows[i]) begin
      dev_op(rows[i].a, rows[i].w, 1'b0, 1'b1, 1'b1);
      dev_op(rows[i].a, 16'h0000, 1'b1, rows[i].bl, rows[i].bh);
      check(d, rows[i].e);
    end
    // code 5 is out of range and must leave the last rate in place
    for (int r = 0; r < 6; r++) begin
      dev_op(DEV_RRATE, 16'(r), 1'b0, 1'b1, 1'b1);
      dev_op(DEV_RRATE, 16'h0000, 1'b1, 1'b1, 1'b1);
      check(d, (r < 5) ? 16'(r) : 16'h0004);
    end
    check(16'(&tx_oe_n), 16'h0001);
    output_drive_enable_in <= 1'b1;
    repeat (2) @(posedge clk_sys);
    check({8'h00, tx_oe_n[7:0]}, 16'h00c3);
    repeat (24) begin sbclk <= ~sbclk; @(posedge clk_sys); end
    check(16'(frame_hi), 16'h0001);
    frame <= 1'b1;
    repeat (24) begin sbclk <= ~sbclk; @(posedge clk_sys); end
    check(16'(frame_hi), 16'h0000);
    nrst <= 1'b0;
    sync_mode <= 1'b0;
    @(posedge clk_sys);
    check(16'(&tx_oe_n), 16'h0001);
    check(16'(u_tsw_if.d_dev_oe_n), 16'h0003);
    nrst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    dev_op(DEV_FLT0, 16'h0000, 1'b1, 1'b1, 1'b1);
    check(d, 16'h0000);
    dev_op(DEV_FLT0, 16'h1234, 1'b0, 1'b1, 1'b1);
    dev_op(DEV_FLT0, 16'h0000, 1'b1, 1'b1, 1'b1);
    check(d, 16'h1234);
    hrd(H_STAT, d);
    check(d & 16'h0007, 16'h0002);
    check({8'h00, tx_oe_n[7:0]}, 16'h0034);
    // a full fifo holds off the acknowledge until the host gives up
    for (int k = 0; k <= FIFO_DEP; k++) begin
      dev_op(DEV_TXFIFO, 16'(k), 1'b0, 1'b1, 1'b1);
    end
    hrd(H_STAT, d);
    check(d & 16'h0007, 16'h0006);
    dev_op(DEV_STAT, 16'h0000, 1'b1, 1'b1, 1'b1);
    check(d, 16'h0002);
    // standby bit keeps drive, upper pins show status
    output_drive_enable_in <= 1'b0;
    dev_op(DEV_CR, 16'h0003, 1'b0, 1'b1, 1'b1);
    check(tx_oe_n[15:0], 16'h0034);
    check({8'h00, tx[15:8]}, 16'h00ed);
    stop_test();
  end
endmodule
`default_nettype wire
